// ==== hw/flash_pe_pkg.sv ====
// Purpose: shared constants and carriers for the flash program/erase block
// Assumes: 8-bit cpu bus, 16-bit addresses
// Notes:   register addresses are parameters of the top module
package flash_pe_pkg;
  // control register bit positions
  localparam int CTL_PROGRAM  = 0;
  localparam int CTL_ERASE    = 1;
  localparam int CTL_MARGIN   = 2;
  localparam int CTL_HV       = 3;
  localparam int CTL_SIZE_LO  = 4;
  localparam int CTL_SIZE_HI  = 5;
  localparam int CTL_PUMP_DIV = 7;
  localparam logic [7:0] CTL_RESET     = 8'h00;
  localparam logic [7:0] PROTECT_RESET = 8'h00;
  // default register addresses
  localparam logic [15:0] ADDR_LOWER_CONTROL = 16'hFE08;
  localparam logic [15:0] ADDR_UPPER_PROTECT = 16'hFF80;
  localparam logic [15:0] ADDR_LOWER_PROTECT = 16'hFF81;
  // lower array window and erase block bounds
  localparam logic [15:0] LOWER_START = 16'h1000;
  localparam logic [15:0] LOWER_END   = 16'h7FFF;
  localparam logic [15:0] LOWER_HALF  = 16'h4000;
  localparam logic [15:0] EIGHT_ROW_MASK = 16'hFE00;
  localparam logic [15:0] ROW_MASK       = 16'hFFC0;
  localparam logic [15:0] BLOCK_512_SPAN = 16'h01FF;
  localparam logic [15:0] ROW_SPAN       = 16'h003F;
  // protect range starts
  localparam logic [15:0] UP_P3 = 16'hC000;
  localparam logic [15:0] UP_P2 = 16'hA000;
  localparam logic [15:0] UP_P1 = 16'h9000;
  localparam logic [15:0] UP_P0 = 16'h8000;
  localparam logic [15:0] LO_P3 = 16'h4000;
  localparam logic [15:0] LO_P2 = 16'h2000;
  localparam logic [15:0] LO_P1 = 16'h1000;
  localparam logic [15:0] LO_P0 = 16'h1000;
  localparam logic [15:0] NO_PROTECT = 16'hFFFF;
  // erase sizes
  localparam logic [1:0] SIZE_FULL = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_512  = 2'h2;
  localparam logic [1:0] SIZE_ROW  = 2'h3;
  localparam int PAGE_BYTES    = 8;
  localparam int MARGIN_EXTRA  = 8;
  localparam logic [7:0] ERASED_BYTE = 8'h00;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [15:0] addr;
    logic [7:0]  data;
  } cpu_req_t;

  typedef struct packed {
    logic        ready;
    logic [7:0]  data;
  } cpu_resp_t;

  typedef struct packed {
    logic        program_select;
    logic        erase_select;
    logic        high_voltage_enable;
    logic        margin_select;
    logic [15:0] block_start;
    logic [15:0] block_end;
  } array_ctl_t;
endpackage : flash_pe_pkg

// ==== hw/flash_pump_clock.sv ====
// Purpose: pump phase clocks from the pll vco clock
// Assumes: pll_vco_clock is a free-running input sampled on clk
// Notes:   phases are quadrature at half the selected pump rate
`timescale 1ns/1ps
`default_nettype none
module flash_pump_clock
  import flash_pe_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // controls
  input  wire logic pll_vco_clock,
  input  wire logic run,
  input  wire logic pump_divide_select,
  // phases
  output logic      pump_phase_a,
  output logic      pump_phase_b
);
  logic       vco_q;
  logic       next_vco_q;
  logic [2:0] count;
  logic [2:0] next_count;
  logic       next_a;
  logic       next_b;

  always_comb begin
    next_vco_q = pll_vco_clock;
    next_count = count;
    next_a     = pump_phase_a;
    next_b     = pump_phase_b;
    if (!run) begin
      next_count = 3'h0;
      next_a     = 1'b0;
      next_b     = 1'b0;
    end else if (pll_vco_clock && !vco_q) begin
      // four vco edges make one phase cycle for /2, eight for /4
      next_count = pump_divide_select ? count + 3'h1 :
                   {1'b0, count[1:0] + 2'h1};
      if (pump_divide_select) begin
        next_a = count[2] ^ count[1];
        next_b = count[2];
      end else begin
        next_a = count[1] ^ count[0];
        next_b = count[1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      vco_q        <= 1'b0;
      count        <= 3'h0;
      pump_phase_a <= 1'b0;
      pump_phase_b <= 1'b0;
    end else begin
      vco_q        <= next_vco_q;
      count        <= next_count;
      pump_phase_a <= next_a;
      pump_phase_b <= next_b;
    end
  end
endmodule : flash_pump_clock
`default_nettype wire

// ==== hw/flash_program_erase_protect.sv ====
// Purpose: control, protection and sequencing for the lower flash array
// Assumes: cpu holds req until resp.ready; array core outside this block
// Notes:   erase/program masks drive array core; pump phases go to pump
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_protect
  import flash_pe_pkg::*;
#(
  parameter logic [15:0] CONTROL_ADDR = ADDR_LOWER_CONTROL,
  parameter logic [15:0] UP_PROT_ADDR = ADDR_UPPER_PROTECT,
  parameter logic [15:0] LO_PROT_ADDR = ADDR_LOWER_PROTECT
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // cpu bus
  input  wire cpu_req_t  req,
  output cpu_resp_t      resp,
  // array read data from core
  input  wire logic [7:0] array_rdata,
  // pump
  input  wire logic       pll_vco_clock,
  output logic            pump_phase_a,
  output logic            pump_phase_b,
  // array core controls
  output array_ctl_t      array_ctl,
  output logic [63:0]     page_data,
  output logic [15:0]     page_addr
);
  logic [7:0]  control;
  logic [7:0]  next_control;
  logic [7:0]  upper_array_protect;
  logic [7:0]  next_upper_protect;
  logic [7:0]  lower_array_protect;
  logic [7:0]  next_lower_protect;
  logic [15:0] target;
  logic [15:0] next_target;
  logic        target_valid;
  logic        next_target_valid;
  logic [63:0] next_page_data;
  logic [15:0] next_page_addr;
  logic        margin_ok;
  logic        next_margin_ok;
  logic [3:0]  wait_count;
  logic [3:0]  next_wait_count;
  cpu_resp_t   next_resp;
  array_ctl_t  next_array_ctl;
  logic [15:0] blk_start;
  logic [15:0] blk_end;
  logic [15:0] lo_bound;
  logic        in_lower;
  logic        blocked;
  logic        is_ctl;
  logic        is_up;
  logic        is_lo;
  logic        pump_run;

  assign in_lower = req.addr >= LOWER_START && req.addr <= LOWER_END;
  assign is_ctl = req.addr == CONTROL_ADDR;
  assign is_up  = req.addr == UP_PROT_ADDR;
  assign is_lo  = req.addr == LO_PROT_ADDR;

  always_comb begin
    lo_bound = NO_PROTECT;
    if (lower_array_protect[3]) lo_bound = LO_P3;
    if (lower_array_protect[2]) lo_bound = LO_P2;
    if (lower_array_protect[1]) lo_bound = LO_P1;
    if (lower_array_protect[0]) lo_bound = LO_P0;
  end

  always_comb begin
    blk_start = target;
    blk_end   = target;
    if (control[CTL_ERASE]) begin
      case ({control[CTL_SIZE_HI], control[CTL_SIZE_LO]})
        SIZE_FULL: begin
          blk_start = LOWER_START;
          blk_end   = LOWER_END;
        end
        SIZE_HALF: begin
          blk_start = target >= LOWER_HALF ? LOWER_HALF : LOWER_START;
          blk_end   = target >= LOWER_HALF ? LOWER_END
                                           : LOWER_HALF - 16'h0001;
        end
        SIZE_512: begin
          blk_start = target & EIGHT_ROW_MASK;
          blk_end   = (target & EIGHT_ROW_MASK) | BLOCK_512_SPAN;
        end
        default: begin
          blk_start = target & ROW_MASK;
          blk_end   = (target & ROW_MASK) | ROW_SPAN;
        end
      endcase
    end
  end

  assign blocked = target_valid && (blk_end >= lo_bound);

  assign pump_run = control[CTL_HV];

  always_comb begin
    next_control       = control;
    next_upper_protect = upper_array_protect;
    next_lower_protect = lower_array_protect;
    next_target        = target;
    next_target_valid  = target_valid;
    next_page_data     = page_data;
    next_page_addr     = page_addr;
    next_margin_ok     = margin_ok;
    next_wait_count    = wait_count;
    next_resp          = '0;
    if (req.write && !resp.ready) begin
      next_resp.ready = 1'b1;
      if (is_ctl) begin
        next_control = req.data;
        next_control[6] = 1'b0;
        if (req.data[CTL_PROGRAM] && req.data[CTL_ERASE]) begin
          next_control[CTL_PROGRAM] = control[CTL_PROGRAM];
          next_control[CTL_ERASE]   = control[CTL_ERASE];
        end else if (req.data[CTL_PROGRAM] && control[CTL_ERASE]) begin
          next_control[CTL_PROGRAM] = 1'b0;
        end else if (req.data[CTL_ERASE] && control[CTL_PROGRAM]) begin
          next_control[CTL_ERASE] = 1'b0;
        end
        // high voltage needs program or erase already set
        if (req.data[CTL_HV] && !control[CTL_HV] &&
            !(control[CTL_PROGRAM] || control[CTL_ERASE]))
          next_control[CTL_HV] = 1'b0;
        if (control[CTL_HV] || next_control[CTL_HV])
          next_control[CTL_MARGIN] = 1'b0;
        // margin only right after a program
        if (req.data[CTL_MARGIN] && !control[CTL_MARGIN] && !margin_ok)
          next_control[CTL_MARGIN] = 1'b0;
        // a control write with program and erase both clear drops the old target
        if (!req.data[CTL_PROGRAM] && !req.data[CTL_ERASE])
          next_target_valid = 1'b0;
      end else if (is_up) begin
        // upper protect stored for the upper array
        next_upper_protect = req.data;
      end else if (is_lo) begin
        next_lower_protect = req.data;
      end else if (in_lower &&
                   (control[CTL_PROGRAM] || control[CTL_ERASE]) &&
                   !control[CTL_HV]) begin
        next_target       = req.addr;
        next_target_valid = 1'b1;
        // byte slot from low address bits
        if (control[CTL_PROGRAM]) begin
          next_page_addr = req.addr & ~16'h0007;
          next_page_data[req.addr[2:0]*8 +: 8] = req.data;
        end
      end
    end else if (req.read && !resp.ready) begin
      next_resp.data = 8'h00;
      if (is_ctl) begin
        next_resp.data  = control;
        next_resp.ready = 1'b1;
      end else if (is_up) begin
        next_resp.data  = upper_array_protect;
        next_resp.ready = 1'b1;
      end else if (is_lo) begin
        next_resp.data  = lower_array_protect;
        next_resp.ready = 1'b1;
      end else if (control[CTL_MARGIN] && in_lower) begin
        // margin read stretched by eight cycles
        next_wait_count = wait_count + 4'h1;
        if (wait_count == 4'(MARGIN_EXTRA)) begin
          next_wait_count = 4'h0;
          next_resp.data  = array_rdata;
          next_resp.ready = 1'b1;
        end
      end else begin
        // erased cells return ERASED_BYTE from core as-is
        next_resp.data  = array_rdata;
        next_resp.ready = 1'b1;
      end
    end
    // margin drops when high voltage rises
    if (next_control[CTL_HV])
      next_control[CTL_MARGIN] = 1'b0;
    // protection kills program or erase and high voltage
    if (blocked) begin
      next_control[CTL_PROGRAM] = 1'b0;
      next_control[CTL_ERASE]   = 1'b0;
      next_control[CTL_HV]      = 1'b0;
    end
    // margin window opens after programming pulse
    if (control[CTL_HV] && control[CTL_PROGRAM])
      next_margin_ok = 1'b1;
    else if (control[CTL_ERASE] || next_control[CTL_HV])
      next_margin_ok = 1'b0;
  end

  always_comb begin
    next_array_ctl.program_select      = next_control[CTL_PROGRAM];
    next_array_ctl.erase_select        = next_control[CTL_ERASE];
    next_array_ctl.high_voltage_enable = next_control[CTL_HV];
    next_array_ctl.margin_select       = next_control[CTL_MARGIN];
    next_array_ctl.block_start         = blk_start;
    next_array_ctl.block_end           = blk_end;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      control             <= CTL_RESET;
      upper_array_protect <= PROTECT_RESET;
      lower_array_protect <= PROTECT_RESET;
      target              <= 16'h0000;
      target_valid        <= 1'b0;
      page_data           <= 64'h0;
      page_addr           <= 16'h0000;
      margin_ok           <= 1'b0;
      wait_count          <= 4'h0;
      resp                <= '0;
      array_ctl           <= '0;
    end else begin
      control             <= next_control;
      upper_array_protect <= next_upper_protect;
      lower_array_protect <= next_lower_protect;
      target              <= next_target;
      target_valid        <= next_target_valid;
      page_data           <= next_page_data;
      page_addr           <= next_page_addr;
      margin_ok           <= next_margin_ok;
      wait_count          <= next_wait_count;
      resp                <= next_resp;
      array_ctl           <= next_array_ctl;
    end
  end

  flash_pump_clock u_pump (
    .clk                (clk),
    .resetn             (resetn),
    .pll_vco_clock      (pll_vco_clock),
    .run                (pump_run),
    .pump_divide_select (control[CTL_PUMP_DIV]),
    .pump_phase_a       (pump_phase_a),
    .pump_phase_b       (pump_phase_b)
  );
endmodule : flash_program_erase_protect
`default_nettype wire

// ==== verification/flash_pe_props.sv ====
// Purpose: port checker for flash_program_erase_protect
// Assumes: one clock, sync active-low reset
// Notes:   bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module flash_pe_props
  import flash_pe_pkg::*;
#(
  parameter logic [15:0] CONTROL_ADDR = ADDR_LOWER_CONTROL
)(
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // cpu bus
  input wire cpu_req_t   req,
  input wire cpu_resp_t  resp,
  // core side
  input wire array_ctl_t array_ctl,
  input wire logic       pump_phase_a,
  input wire logic       pump_phase_b
);
  logic       hv, ms, ps, es, arr, last_a, next_last;
  logic [5:0] still, next_still;
  assign hv  = array_ctl.high_voltage_enable;
  assign ms  = array_ctl.margin_select;
  assign ps  = array_ctl.program_select;
  assign es  = array_ctl.erase_select;
  assign arr = req.addr >= LOWER_START && req.addr <= LOWER_END;
  // cycles a pump phase has stood still under high voltage
  always_comb begin
    next_last  = pump_phase_a;
    next_still = still + 6'h01;
    if (!hv || pump_phase_a != last_a) next_still = 6'h00;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      still  <= 6'h00;
      last_a <= 1'b0;
    end else begin
      still  <= next_still;
      last_a <= next_last;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_pair_exclusive: assert property (!(ps && es))
    else $error("program and erase both set");
  a_hv_needs_mode: assert property ($rose(hv) |-> $past(ps || es))
    else $error("high voltage rose without a mode");
  a_margin_hv_excl: assert property (hv && $past(hv) |-> !ms)
    else $error("margin held under high voltage");
  a_pump_quiet: assert property (!hv && !$past(hv) && !$past(hv, 2)
    |-> !pump_phase_a && !pump_phase_b)
    else $error("pump running with high voltage off");
  a_pump_runs: assert property (still < 6'h28)
    else $error("pump phase stuck under high voltage");
  a_ctl_take: assert property (req.write && !resp.ready && !es && !hv
    && req.addr == CONTROL_ADDR && req.data == 8'h01
    |=> ps && resp.ready)
    else $error("program select not taken");
  a_margin_stretch: assert property ($rose(req.read) && ms && arr
    |=> !resp.ready [*8] ##1 resp.ready)
    else $error("margin read not stretched by eight");
  a_plain_read: assert property ($rose(req.read) && !ms |=> resp.ready)
    else $error("plain read not answered next cycle");
endmodule : flash_pe_props
bind flash_program_erase_protect flash_pe_props #(
  .CONTROL_ADDR(CONTROL_ADDR)
) chk_u (.clk(clk), .resetn(resetn), .req(req), .resp(resp),
  .array_ctl(array_ctl), .pump_phase_a(pump_phase_a),
  .pump_phase_b(pump_phase_b));
`default_nettype wire

// ==== verification/flash_program_erase_protect_tb.sv ====
// Purpose: self-checking bench for flash_program_erase_protect
// Assumes: cpu holds a request until ready
// Notes:   table rows, then reset, program and erase cases
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_protect_tb
  import flash_pe_pkg::*;
;
  logic        clk, resetn, vco, pump_a, pump_b;
  cpu_req_t    req;
  cpu_resp_t   resp;
  array_ctl_t  actl;
  logic [7:0]  rdata, q;
  logic [63:0] page_data, exp;
  logic [15:0] page_addr;
  logic [59:0] er;
  int          error_cnt, samples_checked, i, p0, p1;
  // addr, write data, readback
  localparam logic [31:0] ROWS [14] = '{32'hFE08_01_01, 32'hFE08_03_01,
    32'hFE08_00_00, 32'hFE08_02_02, 32'hFE08_03_02, 32'hFE08_00_00,
    32'hFE08_08_00, 32'hFE08_04_00, 32'hFE08_F0_B0, 32'hFE08_00_00,
    32'hFF80_0F_0F, 32'hFF81_05_05, 32'hFF80_00_00, 32'hFF81_00_00};
  // erase kept, control, target, block start, block end
  localparam logic [59:0] ERS [6] = '{60'h0_02_1234_0000_0000,
    60'h1_12_1234_1000_3FFF, 60'h1_22_1234_1200_13FF,
    60'h1_32_2047_2040_207F, 60'h0_32_4010_0000_0000,
    60'h0_12_5000_0000_0000};
  flash_program_erase_protect dut_u (.clk(clk), .resetn(resetn),
    .req(req), .resp(resp), .array_rdata(rdata), .pll_vco_clock(vco),
    .pump_phase_a(pump_a), .pump_phase_b(pump_b), .array_ctl(actl),
    .page_data(page_data), .page_addr(page_addr));
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk(input string s, input logic [63:0] e,
                     input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %0h got %0h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    req <= '{w, ~w, a, d};
    @(posedge clk);
    @(negedge clk);
    while (resp.ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) begin
      error_cnt++;
      test_done();
    end else begin
      q = resp.data;
      @(posedge clk);
      req <= '0;
      @(posedge clk);
    end
  endtask : bus
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("rdata", 64'(e), 64'(q));
  endtask : rd
  // cycles between two rising edges of a pump phase
  task automatic period(output int p);
    int n, k;
    logic last;
    k = 0;
    p = 0;
    last = pump_a;
    for (n = 0; n < 200 && k < 2; n++) begin
      @(negedge clk);
      if (k == 1) p++;
      if (pump_a && !last) k++;
      last = pump_a;
    end
    if (k < 2) begin
      error_cnt++;
      test_done();
    end
  endtask : period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // pll clock runs from time zero
  initial begin
    vco = 1'b0;
    forever #16 vco = ~vco;
  end
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    resetn = 1'b0;
    req = '0;
    rdata = 8'h00;
    exp = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 14; i++) begin
      wr(ROWS[i][31:16], ROWS[i][15:8]);
      rd(ROWS[i][31:16], ROWS[i][7:0]);
    end
    wr(ADDR_LOWER_CONTROL, 8'hF0);
    wr(ADDR_LOWER_PROTECT, 8'h0F);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("array_ctl", 64'h0, 64'(actl));
    rd(ADDR_LOWER_CONTROL, CTL_RESET);
    rd(ADDR_LOWER_PROTECT, PROTECT_RESET);
    rd(ADDR_UPPER_PROTECT, PROTECT_RESET);
    // page fill, slot 3 rewritten last
    // one program per row, only this control used
    wr(ADDR_LOWER_CONTROL, 8'h01);
    for (i = 0; i < 8; i++) begin
      wr(16'h2007 - 16'(i), 8'hA0 + 8'(i));
      exp[8*(7-i) +: 8] = 8'hA0 + 8'(i);
    end
    wr(16'h2003, 8'h55);
    exp[31:24] = 8'h55;
    chk("page_data", exp, page_data);
    chk("page_addr", 64'h2000, 64'(page_addr));
    wr(ADDR_LOWER_CONTROL, 8'h09);
    chk("hv", 64'h1, 64'(actl.high_voltage_enable));
    period(p0);
    wr(ADDR_LOWER_CONTROL, 8'h89);
    period(p1);
    chk("pump period", 64'(2 * p0), 64'(p1));
    wr(ADDR_LOWER_CONTROL, 8'h8D);
    rd(ADDR_LOWER_CONTROL, 8'h89);
    wr(ADDR_LOWER_CONTROL, 8'h81);
    chk("hv", 64'h0, 64'(actl.high_voltage_enable));
    chk("pump", 64'h0, 64'({pump_a, pump_b}));
    wr(ADDR_LOWER_CONTROL, 8'h85);
    wr(ADDR_LOWER_CONTROL, 8'h84);
    rd(ADDR_LOWER_CONTROL, 8'h84);
    rdata <= 8'h5A;
    rd(16'h2000, 8'h5A);
    rdata <= ERASED_BYTE;
    wr(ADDR_LOWER_CONTROL, 8'h00);
    rd(16'h2000, ERASED_BYTE);
    // erase sizes against lower protect from 4000
    // erase steps in order, high voltage kept short
    wr(ADDR_LOWER_PROTECT, 8'h08);
    for (i = 0; i < 6; i++) begin
      er = ERS[i];
      wr(ADDR_LOWER_CONTROL, er[55:48]);
      wr(er[47:32], 8'hFF);
      chk("erase", 64'(er[56]), 64'(actl.erase_select));
      if (er[56]) begin
        chk("start", 64'(er[31:16]), 64'(actl.block_start));
        chk("end", 64'(er[15:0]), 64'(actl.block_end));
      end
      wr(ADDR_LOWER_CONTROL, er[56] ? er[55:48] | 8'h08 : 8'h08);
      chk("hv", 64'(er[56]), 64'(actl.high_voltage_enable));
      wr(ADDR_LOWER_CONTROL, 8'h00);
    end
    test_done();
  end
endmodule : flash_program_erase_protect_tb
`default_nettype wire
